// ### common/lcp_pkg.sv
// Constants, register map and carrier types for the cable-loss and pulse-segment bank
package lcp_pkg;
	localparam int unsigned ADDR_W       = 16;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned IDX_W        = 14;
	localparam int unsigned SEG_COUNT    = 8;
	localparam int unsigned SEG_W        = 7;
	localparam int unsigned CODE_W       = 6;
	localparam int unsigned EQC_W        = 5;
	localparam int unsigned LOS_CNT_W    = 13;

	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_LIU_CTRL   = 14'h0f00;
	localparam logic [IDX_W-1:0] IDX_LOS_STATUS = 14'h0f01;
	localparam logic [IDX_W-1:0] IDX_CABLE_LOSS = 14'h0f07;
	localparam logic [IDX_W-1:0] IDX_SEG_FIRST  = 14'h0f08;
	localparam logic [IDX_W-1:0] IDX_SEG_TWO    = 14'h0f09;

	// Control register field positions
	localparam int unsigned CTRL_EQC_LSB  = 0;
	localparam int unsigned CTRL_EXT_BIT  = 5;
	localparam int unsigned CTRL_SYNC_BIT = 6;

	localparam logic [EQC_W-1:0]  EQC_RESET      = 5'h00;
	localparam logic [EQC_W-1:0]  EQC_ARBITRARY  = 5'h1f;
	localparam logic [SEG_W-1:0]  SEG_RESET      = 7'h00;
	localparam logic [CODE_W-1:0] CODE_RESET     = 6'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO      = 32'h0000_0000;

	// Signal-loss intervals in line bits
	localparam int unsigned DIGITAL_SIGNAL_LOSS_INTERVAL_EXT_BITS    = 4096;
	localparam int unsigned DIGITAL_SIGNAL_LOSS_INTERVAL_NORMAL_BITS = 32;
	localparam int unsigned SEG_CYCLES       = 2;

	typedef struct packed {
		logic             sync_mode;
		logic             ext_los;
		logic [EQC_W-1:0] eq_ctrl;
	} lcp_ctrl_type;

	typedef struct packed {
		logic              sign;
		logic [SEG_W-2:0]  magnitude;
	} lcp_seg_type;

	typedef struct packed {
		logic              valid;
		logic [2:0]        index;
		lcp_seg_type       amp;
	} lcp_tx_type;
endpackage : lcp_pkg

// ### logic/lcp_pulse_seq.sv
// Steps the eight transmit pulse segments out in order per pulse interval
`timescale 1ns/10ps
`default_nettype none
module lcp_pulse_seq #(
	parameter int unsigned SEG_CYCLES = lcp_pkg::SEG_CYCLES
) (
	input  wire logic                                   ref_clk,     // System clock
	input  wire logic                                   nrst,        // Sync reset, low
	input  wire logic                                   arb_mode,    // Arbitrary mode on
	input  wire logic                                   pulse_start, // Start of pulse interval
	input  wire lcp_pkg::lcp_seg_type [lcp_pkg::SEG_COUNT-1:0] segs, // Segment table
	output var  lcp_pkg::lcp_tx_type                    tx_q         // Segment output
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHAPE = 2'b10
	} lcp_seq_state_type;

	localparam int unsigned DW = (SEG_CYCLES > 1) ? $clog2(SEG_CYCLES) : 1;
	localparam logic [DW-1:0] DWELL_LAST = DW'(SEG_CYCLES - 1);
	localparam logic [2:0]    IDX_LAST   = 3'(lcp_pkg::SEG_COUNT - 1);

	lcp_seq_state_type   state_q;
	lcp_seq_state_type   state_d;
	logic [DW-1:0]       dwell_q;
	logic [2:0]          idx_q;
	wire logic           dwell_end;
	wire logic           last_seg;
	wire logic           launch;

	assign dwell_end = (dwell_q == DWELL_LAST);
	assign last_seg  = (idx_q == IDX_LAST);
	// No pulse starts outside arbitrary mode; a segment already out stays valid one cycle after it ends
	assign launch    = arb_mode && pulse_start;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (launch) begin
					state_d = ST_SHAPE;
				end
			end
			ST_SHAPE: begin
				if (!arb_mode || (dwell_end && last_seg && !pulse_start)) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			dwell_q <= '0;
			idx_q   <= '0;
			tx_q    <= '0;
		end else begin
			state_q <= state_d;
			if (launch && (state_q == ST_IDLE || (dwell_end && last_seg))) begin
				dwell_q <= '0;
				idx_q   <= '0;
				tx_q    <= '{valid: 1'b1, index: 3'h0, amp: segs[0]};
			end else if (state_q == ST_SHAPE && arb_mode && !(dwell_end && last_seg)) begin
				dwell_q <= dwell_end ? '0 : dwell_q + DW'(1);
				if (dwell_end) begin
					idx_q <= idx_q + 3'h1;
					tx_q  <= '{valid: 1'b1, index: idx_q + 3'h1, amp: segs[idx_q + 3'h1]};
				end
			end else if (state_d == ST_IDLE) begin
				dwell_q <= '0;
				idx_q   <= '0;
				tx_q    <= '0;
			end
		end
	end
endmodule : lcp_pulse_seq
`default_nettype wire

// ### logic/lcp_bank.sv
// APB register bank: cable-loss code, signal-loss detect, arbitrary pulse segments
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module lcp_bank #(
	parameter int unsigned DIGITAL_SIGNAL_LOSS_INTERVAL_EXT_BITS    = lcp_pkg::DIGITAL_SIGNAL_LOSS_INTERVAL_EXT_BITS,
	parameter int unsigned DIGITAL_SIGNAL_LOSS_INTERVAL_NORMAL_BITS = lcp_pkg::DIGITAL_SIGNAL_LOSS_INTERVAL_NORMAL_BITS,
	parameter int unsigned SEG_CYCLES       = lcp_pkg::SEG_CYCLES
) (
	input  wire logic                        ref_clk,                  // 25 MHz clock
	input  wire logic                        nrst,                     // Sync reset, low
	input  wire logic                        psel,                     // APB select
	input  wire logic                        penable,                  // APB enable
	input  wire logic                        pwrite,                   // APB write
	input  wire logic [lcp_pkg::ADDR_W-1:0]  paddr,                    // APB byte address
	input  wire logic [lcp_pkg::DATA_W-1:0]  pwdata,                   // APB write data
	output logic      [lcp_pkg::DATA_W-1:0]  prdata,                   // APB read data
	output logic                             pready,                   // APB ready
	output logic                             pslverr,                  // APB error
	input  wire logic [lcp_pkg::CODE_W-1:0]  cable_attenuation_code,   // Equalizer setting
	input  wire logic                        rx_data,                  // Line data pin
	input  wire logic                        rx_bit_en,                // Line bit strobe
	input  wire logic                        tx_pulse_start,           // Pulse interval start
	output logic                             receive_signal_loss_alarm,// Signal-loss alarm
	output logic                             arb_mode,                 // Arbitrary mode active
	output logic                             tx_seg_valid,             // Segment valid
	output logic      [2:0]                  tx_seg_index,             // Segment number - 1
	output logic      [lcp_pkg::SEG_W-1:0]   tx_seg_amplitude          // Sign-magnitude amplitude
);
	localparam int unsigned NS = lcp_pkg::SEG_COUNT;
	localparam logic [lcp_pkg::LOS_CNT_W-1:0] LIM_EXT  =
		lcp_pkg::LOS_CNT_W'(DIGITAL_SIGNAL_LOSS_INTERVAL_EXT_BITS);
	localparam logic [lcp_pkg::LOS_CNT_W-1:0] LIM_NORM =
		lcp_pkg::LOS_CNT_W'(DIGITAL_SIGNAL_LOSS_INTERVAL_NORMAL_BITS);

	function automatic logic hit(input logic [lcp_pkg::ADDR_W-1:0] a,
			input logic [lcp_pkg::IDX_W-1:0] idx);
		hit = (a[lcp_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
	endfunction : hit

	lcp_pkg::lcp_ctrl_type                  ctrl_q;
	lcp_pkg::lcp_seg_type  [NS-1:0]         seg_q;
	logic [lcp_pkg::CODE_W-1:0]             code_q;
	logic                                   rx_meta_q;
	logic                                   rx_sync_q;
	logic [lcp_pkg::LOS_CNT_W-1:0]          zero_cnt_q;
	logic                                   los_q;
	logic                                   arb_q;
	logic [lcp_pkg::DATA_W-1:0]             rdata_q;
	logic                                   ready_q;
	logic                                   err_q;
	lcp_pkg::lcp_tx_type                    tx_w;

	wire logic                              setup_ph;
	wire logic                              access_ph;
	wire logic                              wr_fire;
	wire logic                              hit_ctrl;
	wire logic                              hit_stat;
	wire logic                              hit_loss;
	wire logic [NS-1:0]                     hit_seg;
	wire logic                              mapped;
	wire logic [lcp_pkg::LOS_CNT_W-1:0]     los_limit;
	wire logic [lcp_pkg::DATA_W-1:0]        rd_mux;
	logic [lcp_pkg::DATA_W-1:0]             seg_rd;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_fire   = access_ph && pwrite && ready_q && !err_q;
	assign hit_ctrl  = hit(paddr, lcp_pkg::IDX_LIU_CTRL);
	assign hit_stat  = hit(paddr, lcp_pkg::IDX_LOS_STATUS);
	assign hit_loss  = hit(paddr, lcp_pkg::IDX_CABLE_LOSS);

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_seg_dec
			assign hit_seg[gi] = hit(paddr, lcp_pkg::IDX_SEG_FIRST + lcp_pkg::IDX_W'(gi));
		end
	endgenerate

	assign mapped = hit_ctrl || hit_stat || hit_loss || (|hit_seg);

	always_comb begin
		seg_rd = lcp_pkg::DATA_ZERO;
		for (int i = 0; i < NS; i++) begin
			if (hit_seg[i]) begin
				seg_rd = {25'h0000000, seg_q[i]};
			end
		end
	end

	// Upper bits of every register read as zero
	assign rd_mux =
		hit_ctrl ? {25'h0000000, ctrl_q} :
		hit_stat ? {31'h00000000, los_q} :
		hit_loss ? {26'h0000000, code_q} :
		seg_rd;

	// Shorter interval unless the extended option is set
	assign los_limit = ctrl_q.ext_los ? LIM_EXT : LIM_NORM;

	// Zero-wait APB slave: reply staged in setup, shown in access
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_q <= lcp_pkg::DATA_ZERO;
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			ready_q <= setup_ph;
			err_q   <= setup_ph && !mapped;
			rdata_q <= (setup_ph && !pwrite && mapped) ? rd_mux : lcp_pkg::DATA_ZERO;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_q <= '{sync_mode: 1'b0, ext_los: 1'b0, eq_ctrl: lcp_pkg::EQC_RESET};
		end else if (wr_fire && hit_ctrl) begin
			ctrl_q <= pwdata[lcp_pkg::CTRL_SYNC_BIT:lcp_pkg::CTRL_EQC_LSB];
		end
	end

	generate
		for (gi = 0; gi < NS; gi++) begin : g_seg_reg
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					seg_q[gi] <= lcp_pkg::SEG_RESET;
				end else if (wr_fire && hit_seg[gi]) begin
					seg_q[gi] <= pwdata[lcp_pkg::SEG_W-1:0];
				end
			end
		end
	endgenerate

	// Cable-loss code tracks the equalizer every cycle
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			code_q <= lcp_pkg::CODE_RESET;
		end else begin
			code_q <= cable_attenuation_code;
		end
	end

	// Line data comes from a pin, so two flops first
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_meta_q <= 1'b0;
			rx_sync_q <= 1'b0;
		end else begin
			rx_meta_q <= rx_data;
			rx_sync_q <= rx_meta_q;
		end
	end

	// Counts consecutive zero bits; alarm holds until a one arrives
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			zero_cnt_q <= '0;
			los_q      <= 1'b0;
		end else if (rx_bit_en) begin
			if (rx_sync_q) begin
				zero_cnt_q <= '0;
				los_q      <= 1'b0;
			end else if (zero_cnt_q < los_limit) begin
				zero_cnt_q <= zero_cnt_q + lcp_pkg::LOS_CNT_W'(1);
				los_q      <= (zero_cnt_q + lcp_pkg::LOS_CNT_W'(1)) >= los_limit;
			end else begin
				los_q      <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			arb_q <= 1'b0;
		end else begin
			arb_q <= (ctrl_q.eq_ctrl == lcp_pkg::EQC_ARBITRARY);
		end
	end

	lcp_pulse_seq #(
		.SEG_CYCLES (SEG_CYCLES)
	) u_seq (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.arb_mode    (arb_q),
		.pulse_start (tx_pulse_start),
		.segs        (seg_q),
		.tx_q        (tx_w)
	);

	assign prdata                    = rdata_q;
	assign pready                    = ready_q;
	assign pslverr                   = err_q;
	assign receive_signal_loss_alarm = los_q;
	assign arb_mode                  = arb_q;
	assign tx_seg_valid              = tx_w.valid;
	assign tx_seg_index              = tx_w.index;
	assign tx_seg_amplitude          = tx_w.amp;
endmodule : lcp_bank
`default_nettype wire

// ### tb/lcp_bank_sva.sv
// Port checker for the cable-loss and pulse-segment bank
`timescale 1ns/10ps
`default_nettype none
module lcp_bank_sva (
	input wire logic                       ref_clk,                   // Clock
	input wire logic                       nrst,                      // Reset, low
	input wire logic                       psel,                      // APB select
	input wire logic                       penable,                   // APB enable
	input wire logic                       pwrite,                    // APB write
	input wire logic [lcp_pkg::ADDR_W-1:0] paddr,                     // APB address
	input wire logic [lcp_pkg::DATA_W-1:0] prdata,                    // APB read data
	input wire logic                       pready,                    // APB ready
	input wire logic                       pslverr,                   // APB error
	input wire logic [lcp_pkg::CODE_W-1:0] cable_attenuation_code,    // Equalizer code
	input wire logic                       rx_bit_en,                 // Bit strobe
	input wire logic                       tx_pulse_start,            // Pulse start
	input wire logic                       receive_signal_loss_alarm, // Alarm
	input wire logic                       arb_mode,                  // Arbitrary mode
	input wire logic                       tx_seg_valid,              // Segment valid
	input wire logic [2:0]                 tx_seg_index               // Segment index
);
	logic setup_w;
	assign setup_w = psel && !penable;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_pready; setup_w |=> pready; endproperty
	property p_clos;
		setup_w && !pwrite && paddr == 16'h3c1c && $stable(cable_attenuation_code)
		|=> prdata == {26'h0, $past(cable_attenuation_code)};
	endproperty
	property p_seg_rsv; setup_w && paddr[15:5] == 11'h1e1 |=> prdata[31:7] == 25'h0; endproperty
	property p_err; setup_w && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0; endproperty
	property p_arb_off; !arb_mode [*2] |-> !tx_seg_valid; endproperty
	property p_start;
		arb_mode && tx_pulse_start && !tx_seg_valid |=> tx_seg_valid && tx_seg_index == 3'h0;
	endproperty
	property p_hold;
		tx_seg_valid && $changed(tx_seg_index) ##1 arb_mode |-> $stable(tx_seg_index);
	endproperty
	property p_order;
		tx_seg_valid && $past(tx_seg_valid) && $changed(tx_seg_index)
		|-> tx_seg_index == $past(tx_seg_index) + 3'h1;
	endproperty
	property p_los; $rose(receive_signal_loss_alarm) |-> $past(rx_bit_en); endproperty
	a_pready: assert property (p_pready) else $error("no ready after setup");
	a_clos: assert property (p_clos) else $error("cable code read wrong");
	a_seg_rsv: assert property (p_seg_rsv) else $error("segment spare bits set");
	a_err: assert property (p_err) else $error("misaligned access not refused");
	a_arb_off: assert property (p_arb_off) else $error("segments sent outside mode");
	a_start: assert property (p_start) else $error("pulse did not start at one");
	a_hold: assert property (p_hold) else $error("segment held too short");
	a_order: assert property (p_order) else $error("segment order broken");
	a_los: assert property (p_los) else $error("alarm rose off strobe");
	c_pulse: cover property (tx_seg_valid && tx_seg_index == 3'h7);
	c_los: cover property ($rose(receive_signal_loss_alarm));
	c_err: cover property (pready && pslverr);
endmodule : lcp_bank_sva
bind lcp_bank lcp_bank_sva u_sva (.*);
`default_nettype wire

// ### tb/lcp_line_model.sv
// Line side model: bit strobes, receive data and pulse starts
`timescale 1ns/10ps
`default_nettype none
module lcp_line_model (
	input  wire logic ref_clk,        // Clock
	input  wire logic nrst,           // Reset, low
	input  wire logic loss_i,         // Line dead
	input  wire logic tx_en_i,        // Request pulses
	output var  logic rx_data,        // Line data
	output var  logic rx_bit_en,      // Bit strobe
	output var  logic tx_pulse_start  // Pulse start
);
	logic [4:0] cnt_q;
	// Pulses 20 cycles apart keeps starts beyond a full pulse
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cnt_q          <= 5'h00;
			rx_data        <= 1'b0;
			rx_bit_en      <= 1'b0;
			tx_pulse_start <= 1'b0;
		end else begin
			cnt_q          <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
			rx_bit_en      <= cnt_q[1:0] == 2'h0;
			tx_pulse_start <= tx_en_i && cnt_q == 5'h00;
			if (cnt_q[1:0] == 2'h0)
				rx_data <= !loss_i && !rx_data;
		end
	end
endmodule : lcp_line_model
`default_nettype wire

// ### tb/lcp_bank_tb.sv
// Self-checking bench for the cable-loss and pulse-segment bank
`timescale 1ns/10ps
`default_nettype none
module lcp_bank_tb;
	logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, rx_data, rx_bit_en;
	logic tx_pulse_start, receive_signal_loss_alarm, arb_mode, tx_seg_valid, loss, tx_en;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] cable_attenuation_code;
	logic [2:0] tx_seg_index;
	logic [6:0] tx_seg_amplitude, seen [8];
	logic er;
	int error_cnt, checks, cyc, vcnt, zcnt, n;
	lcp_bank #(.DIGITAL_SIGNAL_LOSS_INTERVAL_EXT_BITS(16)) DUT (.*);
	lcp_line_model u_line (.ref_clk(ref_clk), .nrst(nrst), .loss_i(loss), .tx_en_i(tx_en),
		.rx_data(rx_data), .rx_bit_en(rx_bit_en), .tx_pulse_start(tx_pulse_start));
	always #20 ref_clk = !ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (tx_seg_valid === 1'b1) begin
			seen[tx_seg_index] = tx_seg_amplitude;
			vcnt++;
		end
		if (loss && rx_bit_en && receive_signal_loss_alarm === 1'b0)
			zcnt++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// Holds the request until ready is sampled high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	initial begin
		ref_clk = 0; nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0000;
		pwdata = 32'h0; cable_attenuation_code = 6'h00; loss = 0; tx_en = 0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 16'h3c1c + 16'(4 * i), 32'h0);
			cmp("reset value", 32'h0, rd);
		end
		cable_attenuation_code <= 6'h21;
		apb(1'b1, 16'h3c1c, 32'hff);
		apb(1'b0, 16'h3c1c, 32'h0);
		cmp("cable loss", 32'h21, rd);
		// Host-style threshold poll over one 175-cycle window
		cable_attenuation_code <= 6'h0c;
		n = cyc;
		while (cyc - n < 175) begin
			apb(1'b0, 16'h3c1c, 32'h0);
			cmp("loss poll", 32'h0c, rd);
		end
		for (int i = 0; i < 8; i++)
			apb(1'b1, 16'h3c20 + 16'(4 * i), 32'hffffff80 | (32'h41 + 32'(i * 19)));
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 16'h3c20 + 16'(4 * i), 32'h0);
			cmp("segment", (32'h41 + 32'(i * 19)) & 32'h7f, rd);
		end
		apb(1'b0, 16'h3ff0, 32'h0);
		cmp("unmapped", 32'h1, {31'h0, er});
		apb(1'b0, 16'h3c21, 32'h0);
		cmp("misaligned", 32'h1, {31'h0, er});
		tx_en <= 1'b1;
		repeat (60) @(posedge ref_clk);
		cmp("idle segments", 32'h0, 32'(vcnt));
		apb(1'b1, 16'h3c00, 32'h1f);
		// Mode flag registers one cycle after the control write lands
		repeat (2) @(posedge ref_clk);
		cmp("arb mode", 32'h1, {31'h0, arb_mode});
		repeat (60) @(posedge ref_clk);
		for (int i = 0; i < 8; i++)
			cmp("sent segment", (32'h41 + 32'(i * 19)) & 32'h7f, {25'h0, seen[i]});
		tx_en <= 1'b0;
		apb(1'b1, 16'h3c00, 32'h7f);
		// Start the dead line right after a one bit so the count is fixed
		@(posedge ref_clk iff (rx_bit_en === 1'b1 && rx_data === 1'b1));
		zcnt = 0;
		loss <= 1'b1;
		n = 0;
		while (receive_signal_loss_alarm !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		cmp("zero bits", 32'h1, {31'h0, zcnt >= 16 && zcnt <= 17});
		apb(1'b0, 16'h3c04, 32'h0);
		cmp("alarm status", 32'h1, rd);
		loss <= 1'b0;
		repeat (20) @(posedge ref_clk);
		cmp("alarm clear", 32'h0, {31'h0, receive_signal_loss_alarm});
		end_sim();
	end
endmodule : lcp_bank_tb
`default_nettype wire
